// *** dv/rpi_mac_model.sv ***
/*
  mac seen from the pin block: drives the transmit pins.
  assumes the caller steps it just after a rising edge of pclk.
*/
module rpi_mac_model
  import rpi_pkg::*;
(
  input wire logic pclk,
  output logic tx_en,
  output logic txd0,
  output logic txd1
);
  timeunit 1ns;
  timeprecision 1ps;
  rpi_dibit_t last = 2'h0;
  initial begin
    tx_en = 1'b0;
    txd0 = 1'b1;
    txd1 = 1'b1;
  end
  // data is only meaningful with enable, so idle dibits are scrambled on purpose
  task automatic send(input logic en, input rpi_dibit_t d);
    tx_en <= en;
    txd1 <= en ? d[1] : ~last[1];
    txd0 <= en ? d[0] : ~last[0];
    last = en ? d : ~last;
  endtask
endmodule

// *** dv/tb.sv ***
/*
  self-checking bench of the pin block over apb and its mac pins.
  assumes the mac model and the pad resolution made here.
*/
`include "rpi_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb
  import rpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, crs_dv_o, crs_dv_oe, rx_er_o, rx_er_oe, ref_clk_oe, clk50;
  logic irq_o, irq_oe, tx_en, txd0, mac_txd1, txd1_o, txd1_oe, ctv, irq_line;
  logic [1:0] rxd, ctd;
  logic strap = 1'b1, crv = 1'b0, cre = 1'b0;
  logic [1:0] crd = 2'h0;
  logic [7:0] evt = 8'h0;
  logic [13:0] rows [4] = '{14'b1_10_0_1_01_1_10_0_1_01, 14'b1_11_1_1_10_1_11_1_1_10,
    14'b0_01_0_0_11_0_00_0_0_00, 14'b1_00_0_1_11_1_00_0_1_11};
  int error_cnt = 0, check_count = 0, cyc = 0;
  // pads: pulls hold the strap level on crs_pin and rxer_pin whenever the block is not driving; txd1_pin falls back to mac_txd1
  wire crs_pin = crs_dv_oe ? crs_dv_o : strap;
  wire rxer_pin = rx_er_oe ? rx_er_o : strap;
  wire txd1_pin = txd1_oe ? txd1_o : mac_txd1;
  always #10 pclk = ~pclk;
  rpi_mac_model mac (.pclk(pclk), .tx_en(tx_en), .txd0(txd0), .txd1(mac_txd1));
  rpi_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crs_dv_i(crs_pin), .crs_dv_o(crs_dv_o), .crs_dv_oe(crs_dv_oe), .rx_er_i(rxer_pin),
    .rx_er_o(rx_er_o), .rx_er_oe(rx_er_oe), .rxd(rxd), .ref_clk_oe(ref_clk_oe),
    .clk_from_crystal_50m(clk50), .irq_output_o(irq_o), .irq_output_oe(irq_oe),
    .tx_en(tx_en), .txd0(txd0), .txd1_i(txd1_pin), .txd1_o(txd1_o), .txd1_oe(txd1_oe),
    .core_rx_valid(crv), .core_rx_dibit(crd), .core_rx_err(cre), .core_tx_valid(ctv),
    .core_tx_dibit(ctd), .core_irq_evt(evt), .irq_line(irq_line));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the bench timeout ends a wait that never sees pready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic eerr);
    apb(1'b0, idx, 32'h0);
    `CHK(rd, exp)
    `CHK(err, eerr)
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= 8'h0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    `CHK({crs_dv_oe, rx_er_oe, ref_clk_oe, clk50}, 4'he)
    strap = 1'b0;
    rdchk(`RPI_IDX_STRAP, 32'h7, 1'b0);
    `CHK(rd[`RPI_STRAP_WAKE_EN_BIT], 1'b1)
    rdchk(`RPI_IDX_CTRL, 32'h0, 1'b0);
    rdchk(`RPI_IDX_IRQ_ENABLE, `RPI_IRQ_ENABLE_RST, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      {crv, crd, cre} <= rows[i][13:10];
      mac.send(rows[i][9], rows[i][8:7]);
      @(posedge pclk);
      #1;
      `CHK({crs_dv_o, rxd, rx_er_o}, rows[i][6:3])
      `CHK({ctv, ctd}, rows[i][2:0])
    end
    $display("test data rows done");
    apb(1'b1, `RPI_IDX_CTRL, 32'h1 << `RPI_CTRL_CLK50_BIT);
    @(posedge pclk);
    #1;
    `CHK({ref_clk_oe, clk50}, 2'h1)
    apb(1'b1, `RPI_IDX_CTRL, 32'h0);
    @(posedge pclk);
    #1;
    `CHK({ref_clk_oe, clk50}, 2'h2)
    rdchk(`RPI_IDX_STRAP, 32'h7, 1'b0);
    rdchk(8'h05, 32'h0, 1'b1);
    rdchk(`RPI_IDX_IRQ_CLEAR, 32'h0, 1'b1);
    $display("test clock mode done");
    apb(1'b1, `RPI_IDX_IRQ_ENABLE, 32'h2);
    pulse(8'h04);
    `CHK({irq_line, irq_oe, irq_o}, 3'h0)
    rdchk(`RPI_IDX_IRQ_STATUS, 32'h4, 1'b0);
    pulse(8'h02);
    `CHK({irq_line, irq_oe, irq_o}, 3'h6)
    apb(1'b1, `RPI_IDX_CTRL, 32'h1 << `RPI_CTRL_IRQ_HIGH_BIT);
    @(posedge pclk);
    #1;
    `CHK(irq_oe, 1'b0)
    apb(1'b1, `RPI_IDX_IRQ_CLEAR, 32'h6);
    rdchk(`RPI_IDX_IRQ_STATUS, 32'h0, 1'b0);
    `CHK({irq_line, irq_oe}, 2'h1)
    apb(1'b1, `RPI_IDX_CTRL, 32'h1 << `RPI_CTRL_WAKE_ALT_BIT);
    pulse(8'h01);
    `CHK({irq_oe, irq_o}, 2'h2)
    $display("test interrupt done");
    apb(1'b1, `RPI_IDX_CTRL, 32'h1 << `RPI_CTRL_NAND_BIT);
    @(posedge pclk);
    {crv, cre} <= 2'h3;
    mac.send(1'b1, 2'h3);
    repeat (3) @(posedge pclk);
    #1;
    `CHK({txd1_oe, txd1_o, ctd[1]}, 3'h4)
    @(posedge pclk);
    mac.send(1'b1, 2'h2);
    repeat (2) @(posedge pclk);
    #1;
    `CHK(txd1_o, 1'b1)
    $display("test nand tree done");
    // second reset with the straps pulled low: latch zeros, wake output stays gated
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK({crs_dv_oe, rx_er_oe, ref_clk_oe, irq_oe, txd1_oe}, 5'h00)
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    `CHK({crs_dv_oe, rx_er_oe, ref_clk_oe, clk50}, 4'he)
    rdchk(`RPI_IDX_STRAP, 32'h0, 1'b0);
    rdchk(`RPI_IDX_CTRL, 32'h0, 1'b0);
    apb(1'b1, `RPI_IDX_CTRL, 32'h1 << `RPI_CTRL_WAKE_ALT_BIT);
    pulse(8'h01);
    `CHK({irq_oe, irq_o}, 2'h0)
    rdchk(`RPI_IDX_IRQ_STATUS, 32'h1, 1'b0);
    $display("test second reset done");
    stop_test();
  end
endmodule

// *** hw/rpi_irq_status.sv ***
/*
  sticky interrupt status with write-one-to-clear and enable gating; assumes
  clear strobe is a one-cycle pulse from the register slave.
*/
module rpi_irq_status
  import rpi_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  rpi_irq_if.ctl irq
);
  logic [W-1:0] status_reg;
  logic [W-1:0] status_next;
  logic pending_reg;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    status_next = status_reg & ~(irq.clr_we ? irq.clr : '0);
    status_next = status_next | irq.evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= |(status_next & irq.en);
    end
  end

  assign irq.status = status_reg;
  assign irq.pending = pending_reg;

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    |irq.evt |-> ##1 ((status_reg & $past(irq.evt)) == $past(irq.evt)))
    else $error("event lost in status");
endmodule

// *** hw/rpi_top.sv ***
/*
  reduced media-independent pin block of the phy: mac-side pins, straps,
  clock mode, interrupt/wake pin, nand-tree output, apb registers.
  assumes pclk is the 50MHz reference; pin inputs are synchronous to it; an
  outer pad ring forms the wires from the *_o/*_oe pairs and a clock mux
  puts pclk on the reference pin while ref_clk_oe is high.
*/
`include "rpi_regs.svh"
module rpi_top
  import rpi_pkg::*;
#(
  parameter bit DEFAULT_25M = 1'b1,
  parameter int IRQ_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crs_dv_i,
  output logic crs_dv_o,
  output logic crs_dv_oe,
  input wire logic rx_er_i,
  output logic rx_er_o,
  output logic rx_er_oe,
  output logic [1:0] rxd,
  output logic ref_clk_oe,
  output logic clk_from_crystal_50m,
  output logic irq_output_o,
  output logic irq_output_oe,
  input wire logic tx_en,
  input wire logic txd0,
  input wire logic txd1_i,
  output logic txd1_o,
  output logic txd1_oe,
  input wire logic core_rx_valid,
  input wire logic [1:0] core_rx_dibit,
  input wire logic core_rx_err,
  output logic core_tx_valid,
  output logic [1:0] core_tx_dibit,
  input wire logic [IRQ_W-1:0] core_irq_evt,
  output logic irq_line
);
  rpi_irq_if #(.W(IRQ_W)) irq_bus ();

  logic [31:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic strap_done_reg;
  logic [1:0] station_address_strap_reg;
  logic wake_signal_enable_strap_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic crs_dv_reg;
  logic rx_er_reg;
  logic [1:0] rxd_reg;
  logic pins_out_reg;
  logic ref_clk_oe_reg;
  logic clk50_reg;
  logic irq_oe_reg;
  logic irq_line_reg;
  logic txd1_o_reg;
  logic txd1_oe_reg;
  logic tx_valid_reg;
  rpi_dibit_t tx_dibit_reg;

  logic [7:0] word_idx;
  logic access;
  logic wr_fire;
  logic rd_ok;
  logic wr_ok;
  logic [31:0] rd_data;
  logic nand_mode;
  logic irq_high;
  logic wake_alt;
  logic wake_pend;
  logic irq_oe_next;
  logic [IRQ_W-1:0] evt_vec;

  assign word_idx = paddr[9:2];
  assign access = psel & penable;
  assign wr_fire = access & pready_reg & pwrite & wr_ok;
  assign nand_mode = ctrl_reg[`RPI_CTRL_NAND_BIT];
  assign irq_high = ctrl_reg[`RPI_CTRL_IRQ_HIGH_BIT];
  assign wake_alt = ctrl_reg[`RPI_CTRL_WAKE_ALT_BIT];

  // apb decode; status and strap are read-only, clear is write-only
  always_comb begin
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (word_idx)
      `RPI_IDX_IRQ_STATUS: begin
        rd_data[IRQ_W-1:0] = irq_bus.status;
        wr_ok = 1'b0;
      end
      `RPI_IDX_IRQ_ENABLE: rd_data[IRQ_W-1:0] = irq_en_reg;
      `RPI_IDX_IRQ_CLEAR: rd_ok = 1'b0;
      `RPI_IDX_STRAP: begin
        rd_data[1:0] = station_address_strap_reg;
        rd_data[`RPI_STRAP_WAKE_EN_BIT] = wake_signal_enable_strap_reg;
        wr_ok = 1'b0;
      end
      `RPI_IDX_CTRL: rd_data = ctrl_reg;
      default: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & (pwrite ? ~wr_ok : ~rd_ok);
      if (access & ~pready_reg & ~pwrite) begin
        prdata_reg <= rd_ok ? rd_data : 32'h0000_0000;
      end
    end
  end

  // clock-select bit resets per variant; software may flip it later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= {24'h00_0000, ~DEFAULT_25M, 7'h00};
    end else if (wr_fire && word_idx == `RPI_IDX_CTRL) begin
      ctrl_reg <= {22'h00_0000, pwdata[9], 1'b0, pwdata[7], 5'h00, pwdata[1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= IRQ_W'(`RPI_IRQ_ENABLE_RST);
    end else if (wr_fire && word_idx == `RPI_IDX_IRQ_ENABLE) begin
      irq_en_reg <= pwdata[IRQ_W-1:0];
    end
  end

  always_comb begin
    evt_vec = core_irq_evt;
  end

  assign irq_bus.evt = evt_vec;
  assign irq_bus.en = irq_en_reg;
  assign irq_bus.clr = pwdata[IRQ_W-1:0];
  assign irq_bus.clr_we = wr_fire && word_idx == `RPI_IDX_IRQ_CLEAR;

  rpi_irq_status #(.W(IRQ_W)) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .irq(irq_bus.ctl)
  );

  // straps are sampled on the first edge after reset release, then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_reg <= 1'b0;
      station_address_strap_reg <= 2'h0;
      wake_signal_enable_strap_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      station_address_strap_reg <= {2{crs_dv_i}};
      wake_signal_enable_strap_reg <= rx_er_i;
    end
  end

  // shared pins stay released until the straps are caught
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_out_reg <= 1'b0;
    end else begin
      pins_out_reg <= strap_done_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crs_dv_reg <= 1'b0;
      rxd_reg <= 2'h0;
      rx_er_reg <= 1'b0;
    end else begin
      crs_dv_reg <= core_rx_valid;
      rxd_reg <= core_rx_valid ? core_rx_dibit : 2'h0;
      rx_er_reg <= core_rx_err;
    end
  end

  // only enables here: the pad mux puts pclk itself on the pin, so no divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_clk_oe_reg <= 1'b0;
      clk50_reg <= 1'b0;
    end else begin
      ref_clk_oe_reg <= strap_done_reg & ~ctrl_reg[`RPI_CTRL_CLK50_BIT];
      clk50_reg <= ctrl_reg[`RPI_CTRL_CLK50_BIT];
    end
  end

  // wake output only reports once the strap enabled wake signalling
  assign wake_pend = irq_bus.status[`RPI_IRQ_WAKE_BIT] & wake_signal_enable_strap_reg;

  always_comb begin
    if (wake_alt) begin
      irq_oe_next = wake_pend;
    end else if (irq_high) begin
      irq_oe_next = ~irq_bus.pending;
    end else begin
      irq_oe_next = irq_bus.pending;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_oe_reg <= 1'b0;
      irq_line_reg <= 1'b0;
    end else begin
      irq_oe_reg <= irq_oe_next & strap_done_reg;
      irq_line_reg <= irq_bus.pending;
    end
  end

  // tx data are taken only while enabled; txd1 reads zero in nand-tree mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_reg <= 1'b0;
      tx_dibit_reg <= 2'h0;
    end else begin
      tx_valid_reg <= tx_en;
      tx_dibit_reg <= tx_en ? {txd1_i & ~nand_mode, txd0} : 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd1_o_reg <= 1'b0;
      txd1_oe_reg <= 1'b0;
    end else begin
      txd1_o_reg <= ~(tx_en & txd0 & crs_dv_i & rx_er_i);
      txd1_oe_reg <= nand_mode;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign crs_dv_o = crs_dv_reg;
  assign crs_dv_oe = pins_out_reg;
  assign rx_er_o = rx_er_reg;
  assign rx_er_oe = pins_out_reg;
  assign rxd = rxd_reg;
  assign ref_clk_oe = ref_clk_oe_reg;
  assign clk_from_crystal_50m = clk50_reg;
  assign irq_output_o = 1'b0;
  assign irq_output_oe = irq_oe_reg;
  assign txd1_o = txd1_o_reg;
  assign txd1_oe = txd1_oe_reg;
  assign core_tx_valid = tx_valid_reg;
  assign core_tx_dibit = tx_dibit_reg;
  assign irq_line = irq_line_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shared pins and straps
  crs_dv_follow_a: assert property (
    pins_out_reg |-> ##1 (crs_dv_o == $past(core_rx_valid)))
    else $error("carrier sense not driven from core");
  pins_on_a: assert property (strap_done_reg |=> crs_dv_oe && rx_er_oe)
    else $error("shared pins not turned to outputs");
  strap_release_a: assert property (!strap_done_reg |-> !crs_dv_oe && !rx_er_oe)
    else $error("shared pin driven before strap capture");
  strap_hold_a: assert property (strap_done_reg |=> $stable(station_address_strap_reg)
    && $stable(wake_signal_enable_strap_reg))
    else $error("strap changed after capture");
  strap_capture_a: assert property ($rose(strap_done_reg) |->
    station_address_strap_reg == {2{$past(crs_dv_i)}})
    else $error("address strap not sampled");
  wake_strap_a: assert property ($rose(strap_done_reg) |->
    wake_signal_enable_strap_reg == $past(rx_er_i))
    else $error("wake strap not sampled");
  rx_err_follow_a: assert property (core_rx_err |=> rx_er_o)
    else $error("receive error not flagged");
  rx_err_clear_a: assert property (!core_rx_err |=> !rx_er_o)
    else $error("receive error flagged without cause");
  rx_dibit_a: assert property (core_rx_valid |=> rxd == $past(core_rx_dibit))
    else $error("receive dibit not sent");
  rx_idle_a: assert property (!core_rx_valid |=> !crs_dv_o && rxd == 2'h0)
    else $error("receive data shown without valid");

  // reference clock
  clk_default_a: assert property (!strap_done_reg |->
    ctrl_reg[`RPI_CTRL_CLK50_BIT] == !DEFAULT_25M)
    else $error("clock mode not at variant default");
  ref_clk_pre_a: assert property (!strap_done_reg |=> !ref_clk_oe)
    else $error("reference clock driven before strap capture");
  ref_clk_mode_a: assert property (strap_done_reg && !ctrl_reg[`RPI_CTRL_CLK50_BIT]
    |=> ref_clk_oe)
    else $error("reference clock not driven in 25MHz mode");
  ref_clk_off_a: assert property (ctrl_reg[`RPI_CTRL_CLK50_BIT] |=> !ref_clk_oe)
    else $error("reference pin used in 50MHz mode");
  clk_sel_a: assert property (wr_fire && word_idx == `RPI_IDX_CTRL |=> ##1
    clk_from_crystal_50m == $past(pwdata[7], 2))
    else $error("clock mode write not applied");

  // interrupt and wake pin; the pin flop lags pending by one cycle
  irq_line_a: assert property (irq_bus.pending |=> irq_line)
    else $error("pending interrupt not reported");
  irq_gate_a: assert property (!strap_done_reg |=> !irq_output_oe)
    else $error("interrupt pin pulled before strap capture");
  irq_polarity_a: assert property (strap_done_reg && !wake_alt && !irq_high
    && irq_bus.pending |=> irq_output_oe)
    else $error("active low interrupt not pulled");
  irq_high_a: assert property (strap_done_reg && !wake_alt && irq_high |=>
    irq_output_oe == !$past(irq_bus.pending))
    else $error("active high interrupt level wrong");
  wake_pull_a: assert property (strap_done_reg && wake_alt && wake_pend
    |=> irq_output_oe)
    else $error("wake event not pulled low");
  wake_gate_a: assert property (wake_alt && !wake_signal_enable_strap_reg
    |=> !irq_output_oe)
    else $error("wake output pulled with wake strap off");
  open_drain_a: assert property (irq_output_o == 1'b0)
    else $error("interrupt pin driven high");

  // transmit pins and nand tree
  tx_take_a: assert property (tx_en && !nand_mode |=> core_tx_valid
    && core_tx_dibit == {$past(txd1_i), $past(txd0)})
    else $error("transmit dibit not taken");
  tx_idle_a: assert property (!tx_en |=> !core_tx_valid && core_tx_dibit == 2'h0)
    else $error("transmit dibit taken without enable");
  nand_out_a: assert property (nand_mode |=> txd1_oe)
    else $error("nand tree output not enabled");
  nand_off_a: assert property (!nand_mode |=> !txd1_oe)
    else $error("nand tree output left enabled");
  nand_value_a: assert property (nand_mode |=> txd1_o ==
    !($past(tx_en) && $past(txd0) && $past(crs_dv_i) && $past(rx_er_i)))
    else $error("nand tree result wrong");
endmodule

// *** include/rpi_irq_if.sv ***
/*
  carrier between the pin block top and its interrupt status module; assumes
  both ends share pclk.
*/
interface rpi_irq_if #(parameter int W = 8);
  logic [W-1:0] evt;
  logic [W-1:0] en;
  logic [W-1:0] clr;
  logic clr_we;
  logic [W-1:0] status;
  logic pending;
  modport ctl (input evt, input en, input clr, input clr_we, output status, output pending);
  modport user (output evt, output en, output clr, output clr_we, input status, input pending);
endinterface

// *** include/rpi_pkg.sv ***
/*
  types of the reduced media-independent pin block; assumes rpi_regs.svh
  holds the numbers.
*/
package rpi_pkg;
  typedef enum logic [1:0] {
    RPI_CLK_25M = 2'h1,
    RPI_CLK_50M = 2'h2
  } rpi_clk_mode_t;
  typedef logic [1:0] rpi_dibit_t;
endpackage

// *** include/rpi_regs.svh ***
/*
  register offsets, field positions, reset values and timing counts of the
  reduced media-independent pin block; assumes a 32-bit apb with word offsets.
*/
// Contract
// - drive carrier-sense/data-valid output to mac
// - latch carrier-sense pull as address bits 1:0
// - 25MHz mode drives 50MHz reference clock out
// - 50MHz mode leaves reference pin unused
// - power-up clock mode depends on variant
// - software selects clock mode via 1Fh bit7
// - drive receive error output to mac
// - latch receive error pull as wake enable
// - interrupt conditions and status via 1Bh; here only status sits at 1Bh, enables at 1Ch and clear at 1Dh
// - interrupt active low default, 1Fh bit9 high
// - wake alternate output pulls low on event
// - interrupt pin is open drain, low only
// - accept two transmit bits per enabled clock
// - nand-tree mode turns txd1 into output
// - send two receive bits per valid clock
`ifndef RPI_REGS_SVH
`define RPI_REGS_SVH

// printed offsets are word indices; byte address is four times the index
`define RPI_IDX_IRQ_STATUS 8'h1b
`define RPI_IDX_IRQ_ENABLE 8'h1c
`define RPI_IDX_IRQ_CLEAR 8'h1d
`define RPI_IDX_STRAP 8'h1e
`define RPI_IDX_CTRL 8'h1f

`define RPI_CTRL_NAND_BIT 0
`define RPI_CTRL_WAKE_ALT_BIT 1
`define RPI_CTRL_CLK50_BIT 7
`define RPI_CTRL_IRQ_HIGH_BIT 9

`define RPI_STRAP_WAKE_EN_BIT 2
`define RPI_IRQ_WAKE_BIT 0
`define RPI_IRQ_ENABLE_RST 32'h0000_0000

// one apb wait state before pready
`define RPI_APB_WAIT_CYCLES 1

`endif
